// >>> hw/sfprs_top.sv
// Purpose: Role selection for the shared pins of a multi-I/O serial flash
// Assumes: Pins and link clock asynchronous; config bits from core logic
// Notes:   Pin outputs registered; width class latched per command at select
`timescale 1ns/1ps
`default_nettype none
`include "sfprs_defines.svh"
module sfprs_top (
    input  wire logic                  clk_in,
    input  wire logic                  rstn_in,
    input  wire logic                  sck_in,
    input  wire logic                  csn_in,
    input  wire logic [3:0]            pin_data_in,
    input  wire logic [7:0]            config_one_volatile_in,
    input  wire logic [7:0]            config_two_volatile_in,
    input  wire logic [7:0]            status_one_nonvolatile_in,
    input  wire sfprs_pkg::sfprs_width_t cmd_width_in,
    input  wire logic                  register_write_command_in,
    input  wire logic                  any_register_write_command_in,
    input  wire logic                  any_write_targets_sr1_cr1_in,
    input  wire logic [3:0]            core_out_data_in,
    input  wire logic [3:0]            core_out_en_in,
    output logic      [3:0]            pin_data_out,
    output logic      [3:0]            pin_oe_out,
    output logic      [3:0]            core_lane_data_out,
    output logic                       sck_rise_out,
    output logic                       sck_fall_out,
    output logic                       write_protect_low_out,
    output logic                       register_write_block_out,
    output logic                       hw_reset_out,
    output var sfprs_pkg::sfprs_roles_t roles_out
);
    logic       sck_s;
    logic       csn_s;
    logic [3:0] pin_s;
    logic       sck_d;
    logic       csn_d;
    logic       quad;
    logic       rst_en;
    logic       wr_dis;
    sfprs_pkg::sfprs_roles_t     next_roles;
    sfprs_pkg::sfprs_width_t     width_lat;
    logic [`SFPRS_CNT_W-1:0]     rst_cnt;
    logic                        rst_cond;
    logic [3:0]                  next_oe;

    // Async pins pass two flops; clock idles low, CS high, data pulled up
    sfprs_sync #(.W(6), .RST_VAL(6'h1F)) u_sync (
        .clk_in  (clk_in),
        .rstn_in (rstn_in),
        .d_in    ({sck_in, csn_in, pin_data_in}),
        .q_out   ({sck_s, csn_s, pin_s})
    );

    assign quad   = config_one_volatile_in[`SFPRS_QUAD_BIT];
    assign rst_en = config_two_volatile_in[`SFPRS_RST_EN_BIT];
    assign wr_dis = status_one_nonvolatile_in[`SFPRS_WR_DISABLE_BIT];

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sck_d <= 1'b0;
            csn_d <= 1'b1;
        end else begin
            sck_d <= sck_s;
            csn_d <= csn_s;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sck_rise_out <= 1'b0;
            sck_fall_out <= 1'b0;
        end else begin
            sck_rise_out <= !csn_s && sck_s && !sck_d;
            sck_fall_out <= !csn_s && !sck_s && sck_d;
        end
    end

    // Width latched at select fall, so a mid-command change waits for the next one
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            width_lat <= sfprs_pkg::SFPRS_W_SINGLE;
        end else if (csn_d && !csn_s) begin
            width_lat <= cmd_width_in;
        end
    end

    always_comb begin
        next_roles             = '0;
        next_roles.lane0_bidir = (width_lat != sfprs_pkg::SFPRS_W_SINGLE);
        next_roles.lane1_bidir = (width_lat != sfprs_pkg::SFPRS_W_SINGLE);
        next_roles.lane2_data  = quad;
        next_roles.lane2_wp    = !quad && wr_dis;
        next_roles.lane3_data  = quad && !csn_s;
        next_roles.lane3_reset = rst_en && (!quad || csn_s);
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            roles_out <= '0;
        end else begin
            roles_out <= next_roles;
        end
    end

    always_comb begin
        next_oe = 4'h0;
        if (!csn_s) begin
            next_oe[0] = next_roles.lane0_bidir && core_out_en_in[0];
            next_oe[1] = core_out_en_in[1];
            next_oe[2] = next_roles.lane2_data && core_out_en_in[2];
            next_oe[3] = next_roles.lane3_data && core_out_en_in[3];
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pin_oe_out   <= 4'h0;
            pin_data_out <= 4'h0;
        end else begin
            pin_oe_out   <= next_oe;
            pin_data_out <= core_out_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            core_lane_data_out <= 4'h0;
        end else begin
            core_lane_data_out[0] <= pin_s[0];
            core_lane_data_out[1] <= next_roles.lane1_bidir ? pin_s[1] : 1'b0;
            core_lane_data_out[2] <= next_roles.lane2_data ? pin_s[2] : 1'b0;
            core_lane_data_out[3] <= next_roles.lane3_data ? pin_s[3] : 1'b0;
        end
    end

    // Host keeps the level firm during writes, so a single sample suffices
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            write_protect_low_out    <= 1'b0;
            register_write_block_out <= 1'b0;
        end else begin
            write_protect_low_out    <= next_roles.lane2_wp && !pin_s[2];
            register_write_block_out <= next_roles.lane2_wp && !pin_s[2]
                && (register_write_command_in
                    || (any_register_write_command_in && any_write_targets_sr1_cr1_in));
        end
    end

    // Any select activity or high level restarts the pulse count
    assign rst_cond = next_roles.lane3_reset && csn_s && !pin_s[3];

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_cnt      <= '0;
            hw_reset_out <= 1'b0;
        end else if (!rst_cond) begin
            rst_cnt      <= '0;
            hw_reset_out <= 1'b0;
        end else if (rst_cnt < `SFPRS_CNT_W'(`SFPRS_RESET_PULSE_CYC)) begin
            rst_cnt      <= rst_cnt + `SFPRS_CNT_W'(1);
            hw_reset_out <= 1'b0;
        end else begin
            hw_reset_out <= 1'b1;
        end
    end

    a_wp_role_gate: assert property (@(posedge clk_in) disable iff (!rstn_in)
        write_protect_low_out |-> !$past(quad) && $past(wr_dis))
        else $error("write protect seen in wrong mode");

    a_quad_no_wp: assert property (@(posedge clk_in) disable iff (!rstn_in)
        $past(quad) |-> !roles_out.lane2_wp && !register_write_block_out)
        else $error("write protect active in quad mode");

    a_lane3_select: assert property (@(posedge clk_in) disable iff (!rstn_in)
        pin_oe_out[3] |-> $past(quad) && !$past(csn_s))
        else $error("lane three driven outside quad select");

    a_reset_quad_off: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ($past(rstn_in) && $past(rst_en) && !$past(quad)) |-> roles_out.lane3_reset)
        else $error("reset role missing with quad off");

    a_reset_needs_csn: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ($past(quad) && !$past(csn_s)) |-> !roles_out.lane3_reset)
        else $error("reset role while selected in quad");

    sequence s_reset_held;
        rst_cond [*8];
    endsequence

    a_reset_pulse: assert property (@(posedge clk_in) disable iff (!rstn_in)
        $rose(hw_reset_out) |-> $past(rst_cond) && rst_cnt == `SFPRS_CNT_W'(`SFPRS_RESET_PULSE_CYC))
        else $error("reset before full pulse time");

    a_reset_assert: assert property (@(posedge clk_in) disable iff (!rstn_in)
        s_reset_held ##0 (rst_cnt == `SFPRS_CNT_W'(`SFPRS_RESET_PULSE_CYC)) ##1 rst_cond |-> ##1 hw_reset_out)
        else $error("reset not raised after pulse time");

    a_reset_disabled: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !$past(rst_en, 2) && !$past(rst_en) |-> !hw_reset_out)
        else $error("reset while feature disabled");

    a_write_block: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (roles_out.lane2_wp && !pin_s[2] && register_write_command_in && next_roles.lane2_wp)
            |-> ##1 register_write_block_out)
        else $error("register write not blocked");
endmodule
`default_nettype wire

// >>> hw/sfprs_defines.svh
// Purpose: Constants for the flash pin role selector
// Assumes: Core clock 250 MHz
// Notes:   Times in ns, cycle counts derived from them
`ifndef SFPRS_DEFINES_SVH
`define SFPRS_DEFINES_SVH
`define SFPRS_CLK_PERIOD_NS   4
`define SFPRS_RESET_PULSE_NS  200
`define SFPRS_RESET_PULSE_CYC ((`SFPRS_RESET_PULSE_NS + `SFPRS_CLK_PERIOD_NS - 1) / `SFPRS_CLK_PERIOD_NS)
`define SFPRS_CNT_W           8
`define SFPRS_QUAD_BIT        1
`define SFPRS_RST_EN_BIT      5
`define SFPRS_WR_DISABLE_BIT  7
`endif

// >>> hw/sfprs_pkg.sv
// Purpose: Types for the flash pin role selector
// Assumes: Nothing
// Notes:   Width classes and role encodings
package sfprs_pkg;
    typedef enum logic [1:0] {
        SFPRS_W_SINGLE = 2'b00,
        SFPRS_W_DUAL   = 2'b01,
        SFPRS_W_QUAD   = 2'b10
    } sfprs_width_t;

    typedef struct packed {
        logic [3:0] in;
        logic [3:0] out;
        logic [3:0] oe;
    } sfprs_lanes_t;

    typedef struct packed {
        logic lane0_bidir;
        logic lane1_bidir;
        logic lane2_data;
        logic lane2_wp;
        logic lane3_data;
        logic lane3_reset;
    } sfprs_roles_t;
endpackage

// >>> hw/sfprs_sync.sv
// Purpose: Two-flop synchroniser for pins
// Assumes: Asynchronous active-low reset
// Notes:   First flop feeds only the second
`timescale 1ns/1ps
`default_nettype none
module sfprs_sync #(
    parameter int        W        = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk_in,
    input  wire logic         rstn_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta  <= RST_VAL;
            q_out <= RST_VAL;
        end else begin
            meta  <= d_in;
            q_out <= meta;
        end
    end
endmodule
`default_nettype wire

// >>> tb/sfprs_host.sv
// Purpose: Host controller model for the pin role selector
// Assumes: Link clock 32 ns, running only while selected
// Notes:   Released lanes 2,3 pulled up; lanes 0,1 float to a toggling pattern
`timescale 1ns/1ps
`default_nettype none
module sfprs_host (
    input  wire logic       clk_in,
    input  wire logic       sel_in,
    input  wire logic [3:0] oe_in,
    input  wire logic [3:0] val_in,
    input  wire logic [3:0] dut_oe_in,
    input  wire logic [3:0] dut_val_in,
    output logic            sck_out,
    output logic            csn_out,
    output logic [3:0]      pin_out
);
    logic flt;
    initial begin
        sck_out = 1'b0;
        #1.3;
        forever begin
            #16;
            sck_out = csn_out ? 1'b0 : ~sck_out;
        end
    end
    initial begin
        csn_out = 1'b1;
        flt = 1'b0;
        forever begin
            @(posedge clk_in);
            csn_out <= ~sel_in;
            flt <= ~flt;
        end
    end
    // Host level wins, so protect pin holds a firm level while driven
    assign pin_out = (oe_in & val_in) | (~oe_in & dut_oe_in & dut_val_in) |
                     (~oe_in & ~dut_oe_in & {2'b11, flt, ~flt});
endmodule
`default_nettype wire

// >>> tb/sfprs_tb_top.sv
// Purpose: Self-checking bench for the pin role selector
// Assumes: Config bits set one frame ahead of the checks
// Notes:   Reset pulse count shared with the design's defines
`timescale 1ns/1ps
`default_nettype none
`include "sfprs_defines.svh"
module sfprs_tb_top;
    logic                    clk_in, rstn_in, sel, rwc, awc, awt, sck, csn, rise, fall, wpl, blk, hrst;
    logic [3:0]              h_oe, h_val, c_dat, c_en, pins, p_dat, p_oe, l_dat;
    logic [7:0]              cfg1, cfg2, st1;
    sfprs_pkg::sfprs_width_t width;
    sfprs_pkg::sfprs_roles_t roles;
    int                      fail_count, tests_run, cyc, rises, falls, n;
    sfprs_host i_host (.clk_in(clk_in), .sel_in(sel), .oe_in(h_oe), .val_in(h_val),
        .dut_oe_in(p_oe), .dut_val_in(p_dat), .sck_out(sck), .csn_out(csn), .pin_out(pins));
    sfprs_top i_dut (.clk_in(clk_in), .rstn_in(rstn_in), .sck_in(sck), .csn_in(csn),
        .pin_data_in(pins), .config_one_volatile_in(cfg1), .config_two_volatile_in(cfg2),
        .status_one_nonvolatile_in(st1), .cmd_width_in(width), .register_write_command_in(rwc),
        .any_register_write_command_in(awc), .any_write_targets_sr1_cr1_in(awt),
        .core_out_data_in(c_dat), .core_out_en_in(c_en), .pin_data_out(p_dat), .pin_oe_out(p_oe),
        .core_lane_data_out(l_dat), .sck_rise_out(rise), .sck_fall_out(fall), .write_protect_low_out(wpl),
        .register_write_block_out(blk), .hw_reset_out(hrst), .roles_out(roles));
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    // Pulses counted mid-cycle, clear of the edge that launches them
    always @(negedge clk_in) begin
        if (rise === 1'b1) rises++;
        if (fall === 1'b1) falls++;
    end
    always @(posedge clk_in) begin
        cyc++;
        // Ceiling well above the few hundred cycles the tests need
        if (cyc == 3000) begin
            fail_count++;
            results();
        end
    end
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [5:0] got, input logic [5:0] exp, input logic [5:0] m, input string s);
        tests_run++;
        if ((got & m) !== (exp & m)) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h exp %h", $time, s, got & m, exp & m);
        end
    endtask
    task automatic drive(input logic q, r, wd, s, input logic [1:0] wide, input logic [3:0] ho, hv, ce, cd,
                         input logic [5:0] m);
        // Brief deselect so the width class is taken at the following select fall
        @(posedge clk_in);
        sel <= 1'b0;
        repeat (4) @(posedge clk_in);
        cfg1[1] <= q;
        cfg2[5] <= r;
        st1[7] <= wd;
        sel <= s;
        width <= sfprs_pkg::sfprs_width_t'(wide);
        {h_oe, h_val, c_en, c_dat} <= {ho, hv, ce, cd};
        repeat (8) @(posedge clk_in);
        @(negedge clk_in);
        chk(roles, {|wide, |wide, q, ~q & wd, q & s, r & (~q | ~s)}, m, "roles");
    endtask
    task automatic wait_reset(input string s);
        n = 0;
        while (hrst !== 1'b1 && n < `SFPRS_RESET_PULSE_CYC + 50) begin
            @(negedge clk_in);
            n++;
        end
        // Sync and register latency add a few cycles beyond the pulse time
        chk({5'h00, n >= `SFPRS_RESET_PULSE_CYC}, 6'h01, 6'h01, s);
        chk({5'h00, n <= `SFPRS_RESET_PULSE_CYC + 8}, 6'h01, 6'h01, s);
    endtask
    initial begin
        {rstn_in, sel, rwc, awc, awt, h_oe, h_val, c_dat, c_en} = '0;
        cfg1  = 8'hfd;
        cfg2  = 8'hdf;
        st1   = 8'h7f;
        width = sfprs_pkg::SFPRS_W_SINGLE;
        repeat (20) @(posedge clk_in);
        rstn_in <= 1'b1;
        drive(1'b0, 1'b0, 1'b1, 1'b1, 2'b00, 4'h4, 4'h0, 4'hf, 4'hf, 6'h3f);
        chk({2'b00, p_oe}, 6'h02, 6'h0f, "single oe");
        chk({2'b00, l_dat}, 6'h00, 6'h0e, "single lanes in");
        chk({5'h00, wpl}, 6'h01, 6'h01, "protect low");
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_in);
            {rwc, awc, awt} <= (k == 0) ? 3'b100 : (k == 1) ? 3'b010 : (k == 2) ? 3'b011 : 3'b000;
            repeat (4) @(posedge clk_in);
            @(negedge clk_in);
            chk({5'h00, blk}, {5'h00, k == 0 || k == 2}, 6'h01, "write block");
        end
        // Protect pin high lets writes pass; request stays on into quad
        @(posedge clk_in);
        h_val <= 4'h4;
        rwc   <= 1'b1;
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
        chk({4'h0, wpl, blk}, 6'h00, 6'h03, "protect high");
        $display("done: single width, protect");
        drive(1'b0, 1'b0, 1'b1, 1'b1, 2'b01, 4'h0, 4'h0, 4'hf, 4'hf, 6'h3f);
        chk({2'b00, p_oe}, 6'h03, 6'h0f, "dual oe");
        chk({2'b00, l_dat}, 6'h03, 6'h0f, "dual lanes in");
        $display("done: dual width");
        @(posedge clk_in);
        rises = 0;
        falls = 0;
        drive(1'b1, 1'b1, 1'b1, 1'b1, 2'b10, 4'h0, 4'h0, 4'hf, 4'ha, 6'h3f);
        chk({p_oe, p_dat[1:0]}, {4'hf, 2'b10}, 6'h3f, "quad drive");
        chk({p_dat, wpl, blk}, {4'ha, 2'b00}, 6'h3f, "quad no protect");
        repeat (16) @(posedge clk_in);
        @(negedge clk_in);
        chk({4'h0, rises != 0, falls != 0}, 6'h03, 6'h03, "sck edges");
        drive(1'b1, 1'b1, 1'b1, 1'b1, 2'b10, 4'hf, 4'h5, 4'h0, 4'h0, 6'h3f);
        chk({2'b00, l_dat}, 6'h05, 6'h0f, "quad lanes in");
        $display("done: quad transfer");
        drive(1'b1, 1'b1, 1'b1, 1'b0, 2'b10, 4'h8, 4'h8, 4'hf, 4'hf, 6'h03);
        chk({2'b00, p_oe}, 6'h00, 6'h0f, "deselect oe");
        @(posedge clk_in);
        h_val <= 4'h0;
        rwc   <= 1'b0;
        wait_reset("reset pulse");
        @(posedge clk_in);
        h_val <= 4'h8;
        repeat (6) @(posedge clk_in);
        @(negedge clk_in);
        chk({5'h00, hrst}, 6'h00, 6'h01, "reset release");
        $display("done: quad reset");
        drive(1'b0, 1'b0, 1'b1, 1'b0, 2'b00, 4'h8, 4'h0, 4'h0, 4'h0, 6'h03);
        repeat (80) @(posedge clk_in);
        @(negedge clk_in);
        chk({5'h00, hrst}, 6'h00, 6'h01, "reset disabled");
        drive(1'b0, 1'b1, 1'b0, 1'b1, 2'b10, 4'h8, 4'h8, 4'h0, 4'h0, 6'h3f);
        @(posedge clk_in);
        h_val <= 4'h0;
        repeat (80) @(posedge clk_in);
        @(negedge clk_in);
        chk({5'h00, hrst}, 6'h00, 6'h01, "reset while selected");
        @(posedge clk_in);
        sel <= 1'b0;
        wait_reset("reset quad off");
        $display("done: reset enable, quad off");
        results();
    end
endmodule
`default_nettype wire
